/* logic/hsc_switch_ctrl.sv */
/*
  Control of four high-side switches: source selection, PWM, supply and load protection.
  Assumes mode and timer inputs are on sys_clk and comparator inputs are asynchronous.
*/
`timescale 1ns/10ps
`default_nettype none
module hsc_switch_ctrl #(
  parameter int OL_FILTER_CYCLES = hsc_pkg::OL_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  // Chip mode and timers
  input wire hsc_pkg::hsc_mode_e chipMode,
  input wire logic timerA,
  input wire logic timerB,
  // Comparators
  input wire logic supplyOverPin,
  input wire logic supplyUnderPin,
  input wire logic [3:0] overCurrentPin,
  input wire logic [3:0] lowCurrentPin,
  // Switch drive
  output logic [3:0] switchOn
);

  localparam int NUM_OUT = hsc_pkg::NUM_OUT;
  localparam int OL_W = $clog2(OL_FILTER_CYCLES + 1);
  localparam int OC_W = hsc_pkg::OC_CNT_W;
  localparam int FW = hsc_pkg::CFG_FIELD_W;

  if (OL_FILTER_CYCLES < 2) begin : g_bad_ol
    $error("Open-load filter must be at least two cycles.");
  end

  if (NUM_OUT != 4) begin : g_bad_num
    $error("The switch ports serve exactly four outputs.");
  end

  // Drive level of a selected source.
  function automatic logic sourceLevel(input logic [2:0] cfg, input logic tA, input logic tB,
                                       input logic pA, input logic pB);
    logic lvl;
    lvl = 1'b0;
    unique case (cfg)
      hsc_pkg::SRC_OFF: lvl = 1'b0;
      hsc_pkg::SRC_ON: lvl = 1'b1;
      hsc_pkg::SRC_TIMER_A: lvl = tA;
      hsc_pkg::SRC_TIMER_B: lvl = tB;
      hsc_pkg::SRC_PWM_A: lvl = pA;
      hsc_pkg::SRC_PWM_B: lvl = pB;
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction : sourceLevel

  // True in the modes whose entry clears every output source to off.
  function automatic logic isOffMode(input hsc_pkg::hsc_mode_e mode);
    return (mode == hsc_pkg::MODE_RESTART) || (mode == hsc_pkg::MODE_FAILSAFE);
  endfunction : isOffMode

  // Two-stage synchronisers for the comparators.
  logic [9:0] meta_r;
  logic [9:0] sync_r;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_r <= 10'h000;
    end else begin
      meta_r <= {supplyOverPin, supplyUnderPin, overCurrentPin, lowCurrentPin};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_r <= 10'h000;
    end else begin
      sync_r <= meta_r;
    end
  end
  wire logic supplyOver = sync_r[9];
  wire logic supplyUnder = sync_r[8];
  wire logic [3:0] ocSeen = sync_r[7:4];
  wire logic [3:0] olSeen = sync_r[3:0];

  // Mode tracking.
  hsc_pkg::hsc_mode_e modePrev_r;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      modePrev_r <= hsc_pkg::MODE_INIT;
    end else begin
      modePrev_r <= chipMode;
    end
  end
  wire logic lowPower = (chipMode == hsc_pkg::MODE_STOP) || (chipMode == hsc_pkg::MODE_SLEEP);
  wire logic cfgWriteOk = !lowPower;
  wire logic offEntry = isOffMode(chipMode) && !isOffMode(modePrev_r);

  // Register write decode.
  wire logic wrCtrlA = regWrite && (regAddr == hsc_pkg::REG_OUT_CTRL_A) && cfgWriteOk;
  wire logic wrCtrlB = regWrite && (regAddr == hsc_pkg::REG_OUT_CTRL_B) && cfgWriteOk;
  wire logic wrSupCfg = regWrite && (regAddr == hsc_pkg::REG_SUPPLY_CFG) && cfgWriteOk;
  wire logic wrSupStat = regWrite && (regAddr == hsc_pkg::REG_SUPPLY_STAT);
  wire logic wrOcStat = regWrite && (regAddr == hsc_pkg::REG_OC_STAT);
  wire logic wrOlStat = regWrite && (regAddr == hsc_pkg::REG_OL_STAT);
  wire logic wrDutyA = regWrite && (regAddr == hsc_pkg::REG_PWM_DUTY_A) && cfgWriteOk;
  wire logic wrDutyB = regWrite && (regAddr == hsc_pkg::REG_PWM_DUTY_B) && cfgWriteOk;
  wire logic wrFreq = regWrite && (regAddr == hsc_pkg::REG_PWM_FREQ) && cfgWriteOk;

  // Supply configuration and fault gating.
  hsc_pkg::hsc_supply_cfg_s supplyCfg_r;
  logic supplyFaultPrev_r;
  logic ovFlag_r;
  logic uvFlag_r;
  wire logic ovActive = supplyOver && !supplyCfg_r.overvoltageShutdownDisable;
  wire logic uvActive = supplyUnder && !supplyCfg_r.undervoltageShutdownDisable;
  wire logic supplyFault = ovActive || uvActive;
  wire logic faultEnd = supplyFaultPrev_r && !supplyFault;
  wire logic faultClear = faultEnd && !supplyCfg_r.recoveryEnable;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      supplyCfg_r <= hsc_pkg::hsc_supply_cfg_s'(hsc_pkg::SUPPLY_CFG_RST);
    end else begin
      supplyCfg_r <= wrSupCfg ? hsc_pkg::hsc_supply_cfg_s'(regWrData[2:0]) : supplyCfg_r;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      supplyFaultPrev_r <= 1'b0;
    end else begin
      supplyFaultPrev_r <= supplyFault;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ovFlag_r <= 1'b0;
    end else begin
      ovFlag_r <= supplyOver
                  || (ovFlag_r && !(wrSupStat && regWrData[hsc_pkg::SUP_OV_BIT]));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      uvFlag_r <= 1'b0;
    end else begin
      uvFlag_r <= supplyUnder
                  || (uvFlag_r && !(wrSupStat && regWrData[hsc_pkg::SUP_UV_BIT]));
    end
  end

  // PWM settings and generators.
  hsc_pkg::hsc_pwm_set_s pwmSet_r [2];
  wire logic [1:0] pwmOut;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pwmSet_r[0] <= '{duty: hsc_pkg::DUTY_RST, fast: 1'b0};
      pwmSet_r[1] <= '{duty: hsc_pkg::DUTY_RST, fast: 1'b0};
    end else begin
      pwmSet_r[0].duty <= wrDutyA ? regWrData : pwmSet_r[0].duty;
      pwmSet_r[1].duty <= wrDutyB ? regWrData : pwmSet_r[1].duty;
      pwmSet_r[0].fast <= wrFreq ? regWrData[0] : pwmSet_r[0].fast;
      pwmSet_r[1].fast <= wrFreq ? regWrData[1] : pwmSet_r[1].fast;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_pwm
    hsc_pwm_gen #(
      .STEP_SLOW(hsc_pkg::PWM_STEP_SLOW_CYCLES),
      .STEP_FAST(hsc_pkg::PWM_STEP_FAST_CYCLES)
    ) u_pwm (
      .sys_clk(sys_clk),
      .reset(reset),
      .setting(pwmSet_r[g]),
      .pwmOut(pwmOut[g])
    );
  end

  // Per-output configuration, drive and load monitoring.
  logic [3:0] switchOn_r;
  logic [3:0] ocFlag_r;
  logic [3:0] olFlag_r;
  wire logic [3:0][2:0] srcCfgAll;
  wire logic [3:0] ocTrip;
  wire logic [3:0] olTrip;
  wire logic [3:0] switchOn_nxt;

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    localparam int LSB = (i % 2 == 0) ? hsc_pkg::CFG_LO_LSB : hsc_pkg::CFG_HI_LSB;
    logic [2:0] srcCfg_r;
    logic [OC_W-1:0] ocCnt_r;
    logic [OL_W-1:0] olCnt_r;
    wire logic wrThis = (i < 2) ? wrCtrlA : wrCtrlB;
    wire logic hwClear = offEntry || faultClear || ocTrip[i];
    wire logic ocCond = switchOn_r[i] && ocSeen[i];
    wire logic olCond = switchOn_r[i] && olSeen[i];
    wire logic olFull = olCnt_r == OL_W'(OL_FILTER_CYCLES - 1);

    assign srcCfgAll[i] = srcCfg_r;
    assign ocTrip[i] = ocCond && (ocCnt_r == OC_W'(hsc_pkg::OC_FILTER_CYCLES - 1));
    assign olTrip[i] = olCond && olFull;
    assign switchOn_nxt[i] = sourceLevel(srcCfg_r, timerA, timerB, pwmOut[0], pwmOut[1])
                             && !supplyFault
                             && !faultClear;

    always_ff @(posedge sys_clk) begin
      if (reset) begin
        srcCfg_r <= hsc_pkg::SRC_OFF;
      end else begin
        srcCfg_r <= hwClear ? hsc_pkg::SRC_OFF
                            : (wrThis ? regWrData[LSB +: FW] : srcCfg_r);
      end
    end

    always_ff @(posedge sys_clk) begin
      if (reset) begin
        ocCnt_r <= '0;
      end else begin
        ocCnt_r <= ocCond ? ocCnt_r + OC_W'(1) : '0;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (reset) begin
        olCnt_r <= '0;
      end else begin
        olCnt_r <= !olCond ? '0 : (olFull ? olCnt_r : olCnt_r + OL_W'(1));
      end
    end
  end

  // Drive register and sticky load flags; a set in the clearing cycle wins.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      switchOn_r <= 4'h0;
    end else begin
      switchOn_r <= switchOn_nxt & ~ocTrip;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ocFlag_r <= 4'h0;
    end else begin
      ocFlag_r <= (ocFlag_r & ~(wrOcStat ? regWrData[3:0] : 4'h0)) | ocTrip;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      olFlag_r <= 4'h0;
    end else begin
      olFlag_r <= (olFlag_r & ~(wrOlStat ? regWrData[3:0] : 4'h0)) | olTrip;
    end
  end

  // Read data, registered and present for one cycle.
  wire logic [7:0] readMux =
    (regAddr == hsc_pkg::REG_OUT_CTRL_A) ? {1'b0, srcCfgAll[1], 1'b0, srcCfgAll[0]} :
    (regAddr == hsc_pkg::REG_OUT_CTRL_B) ? {1'b0, srcCfgAll[3], 1'b0, srcCfgAll[2]} :
    (regAddr == hsc_pkg::REG_SUPPLY_CFG) ? {5'h00, supplyCfg_r} :
    (regAddr == hsc_pkg::REG_SUPPLY_STAT) ? {6'h00, uvFlag_r, ovFlag_r} :
    (regAddr == hsc_pkg::REG_OC_STAT) ? {4'h0, ocFlag_r} :
    (regAddr == hsc_pkg::REG_OL_STAT) ? {4'h0, olFlag_r} :
    (regAddr == hsc_pkg::REG_PWM_DUTY_A) ? pwmSet_r[0].duty :
    (regAddr == hsc_pkg::REG_PWM_DUTY_B) ? pwmSet_r[1].duty :
    (regAddr == hsc_pkg::REG_PWM_FREQ) ? {6'h00, pwmSet_r[1].fast, pwmSet_r[0].fast} :
    (regAddr == hsc_pkg::REG_OUT_STATE) ? {4'h0, switchOn_r} :
    8'h00;

  logic [7:0] rdData_r;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rdData_r <= 8'h00;
    end else begin
      rdData_r <= regRead ? readMux : 8'h00;
    end
  end

  assign regRdData = rdData_r;
  assign switchOn = switchOn_r;

endmodule : hsc_switch_ctrl
`default_nettype wire

/* pkg/hsc_pkg.sv */
/*
  Shared constants, codes and carrier types of the high-side switch controller.
  Assumes a 100 MHz system clock and an 8-bit register port with a 4-bit address.
*/
`default_nettype none
package hsc_pkg;

  // Clock and filter timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int OC_FILTER_NS = 16000;
  localparam int OC_FILTER_CYCLES = (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OC_CNT_W = $clog2(OC_FILTER_CYCLES);
  localparam int OL_FILTER_NS = 64000;
  localparam int OL_FILTER_CYCLES = (OL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // PWM timing: a period is 256 duty steps.
  localparam int PWM_STEPS = 256;
  localparam int PWM_PERIOD_SLOW_NS = 5000000;
  localparam int PWM_PERIOD_FAST_NS = 2500000;
  localparam int PWM_STEP_SLOW_CYCLES = PWM_PERIOD_SLOW_NS / CLK_PERIOD_NS / PWM_STEPS;
  localparam int PWM_STEP_FAST_CYCLES = PWM_PERIOD_FAST_NS / CLK_PERIOD_NS / PWM_STEPS;

  // Register port geometry and offsets.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_OUT = 4;
  localparam logic [3:0] REG_OUT_CTRL_A = 4'h0;
  localparam logic [3:0] REG_OUT_CTRL_B = 4'h1;
  localparam logic [3:0] REG_SUPPLY_CFG = 4'h2;
  localparam logic [3:0] REG_SUPPLY_STAT = 4'h3;
  localparam logic [3:0] REG_OC_STAT = 4'h4;
  localparam logic [3:0] REG_OL_STAT = 4'h5;
  localparam logic [3:0] REG_PWM_DUTY_A = 4'h6;
  localparam logic [3:0] REG_PWM_DUTY_B = 4'h7;
  localparam logic [3:0] REG_PWM_FREQ = 4'h8;
  localparam logic [3:0] REG_OUT_STATE = 4'h9;

  // Field positions.
  localparam int CFG_FIELD_W = 3;
  localparam int CFG_LO_LSB = 0;
  localparam int CFG_HI_LSB = 4;
  localparam int SUP_OV_BIT = 0;
  localparam int SUP_UV_BIT = 1;

  // Values after reset.
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [2:0] SUPPLY_CFG_RST = 3'h0;

  // Source selection of one output.
  typedef enum logic [2:0] {
    SRC_OFF = 3'b000,
    SRC_ON = 3'b001,
    SRC_TIMER_A = 3'b010,
    SRC_TIMER_B = 3'b011,
    SRC_PWM_A = 3'b100,
    SRC_PWM_B = 3'b101
  } hsc_src_e;

  // Chip operating mode.
  typedef enum logic [2:0] {
    MODE_INIT = 3'b000,
    MODE_NORMAL = 3'b001,
    MODE_STOP = 3'b010,
    MODE_SLEEP = 3'b011,
    MODE_RESTART = 3'b100,
    MODE_FAILSAFE = 3'b101
  } hsc_mode_e;

  typedef struct packed {
    logic recoveryEnable;
    logic undervoltageShutdownDisable;
    logic overvoltageShutdownDisable;
  } hsc_supply_cfg_s;

  typedef struct packed {
    logic [7:0] duty;
    logic fast;
  } hsc_pwm_set_s;

endpackage : hsc_pkg
`default_nettype wire

/* logic/hsc_pwm_gen.sv */
/*
  One 8-bit PWM generator with a 200 Hz or 400 Hz period.
  Assumes its settings come from registers on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module hsc_pwm_gen #(
  parameter int STEP_SLOW = hsc_pkg::PWM_STEP_SLOW_CYCLES,
  parameter int STEP_FAST = hsc_pkg::PWM_STEP_FAST_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Settings
  input wire hsc_pkg::hsc_pwm_set_s setting,
  // Waveform
  output logic pwmOut
);

  localparam int CNT_W = $clog2(STEP_SLOW + 1);

  if (STEP_FAST < 1 || STEP_SLOW < STEP_FAST) begin : g_bad_step
    $error("PWM step lengths cannot be served.");
  end

  logic [CNT_W-1:0] stepCnt_r;
  logic [7:0] phase_r;
  logic pwmOut_r;

  wire logic [CNT_W-1:0] stepLimit = setting.fast ? CNT_W'(STEP_FAST - 1) : CNT_W'(STEP_SLOW - 1);
  wire logic stepLast = stepCnt_r >= stepLimit;
  wire logic [7:0] phase_nxt = stepLast ? phase_r + 8'h01 : phase_r;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stepCnt_r <= '0;
      phase_r <= 8'h00;
      pwmOut_r <= 1'b0;
    end else begin
      stepCnt_r <= stepLast ? '0 : stepCnt_r + CNT_W'(1);
      phase_r <= phase_nxt;
      pwmOut_r <= phase_nxt < setting.duty;
    end
  end

  assign pwmOut = pwmOut_r;

endmodule : hsc_pwm_gen
`default_nettype wire

/* tb/hsc_switch_ctrl_props.sv */
/* Port checker of the high-side switch controller.
   Bound to hsc_switch_ctrl by the bench top; sees only that module's ports. */
`timescale 1ns/10ps
`default_nettype none
module hsc_switch_ctrl_props #(
  parameter int OL_FILTER_CYCLES = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Mode, timers and comparators
  input wire hsc_pkg::hsc_mode_e chipMode,
  input wire logic timerA,
  input wire logic timerB,
  input wire logic supplyOverPin,
  input wire logic supplyUnderPin,
  input wire logic [3:0] overCurrentPin,
  input wire logic [3:0] lowCurrentPin,
  // Switch drive
  input wire logic [3:0] switchOn
);
  logic [3:0] quiet_r;
  logic [11:0] ocRun_r;
  logic ovDis_r;
  logic uvDis_r;
  wire logic lowPwr = chipMode == hsc_pkg::MODE_STOP || chipMode == hsc_pkg::MODE_SLEEP;
  wire logic failMode = chipMode == hsc_pkg::MODE_RESTART || chipMode == hsc_pkg::MODE_FAILSAFE;
  wire logic ctrlWr = regWrite && regAddr == hsc_pkg::REG_OUT_CTRL_A;
  wire logic supWr = regWrite && regAddr == hsc_pkg::REG_SUPPLY_CFG && !lowPwr;
  wire logic anyFault = supplyOverPin || supplyUnderPin || overCurrentPin[0];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      quiet_r <= 4'h0;
      ocRun_r <= 12'h000;
      ovDis_r <= 1'b0;
      uvDis_r <= 1'b0;
    end else begin
      quiet_r <= anyFault ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
      ocRun_r <= (overCurrentPin[0] && switchOn[0]) ? ocRun_r + 12'h001 : 12'h000;
      ovDis_r <= supWr ? regWrData[hsc_pkg::SUP_OV_BIT] : ovDis_r;
      uvDis_r <= supWr ? regWrData[hsc_pkg::SUP_UV_BIT] : uvDis_r;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_ctrl0(logic [2:0] code);
    ctrlWr && regWrData[2:0] == code && chipMode == hsc_pkg::MODE_NORMAL && quiet_r > 4'h5;
  endsequence

  AST_ON_WRITE: assert property (s_ctrl0(3'b001) |-> ##2 switchOn[0])
    else $error("output 0 not on after on code");
  AST_OFF_WRITE: assert property (s_ctrl0(3'b000) |-> ##2 !switchOn[0])
    else $error("output 0 not off after off code");
  AST_MODE_OFF: assert property ($rose(failMode) |-> ##2 switchOn == 4'h0)
    else $error("outputs on after restart entry");
  AST_OV_OFF: assert property ((supplyOverPin && !ovDis_r)[*5] |-> switchOn == 4'h0)
    else $error("outputs on during overvoltage");
  AST_UV_OFF: assert property ((supplyUnderPin && !uvDis_r)[*5] |-> switchOn == 4'h0)
    else $error("outputs on during undervoltage");
  AST_OC_CUT: assert property (ocRun_r < 12'd1605)
    else $error("overcurrent output not cut in time");
  AST_OC_HOLD: assert property ($fell(switchOn[0]) && ocRun_r > 12'd1590
      |-> (!switchOn[0])[*8])
    else $error("output back on after overcurrent cut");
  AST_STOP_HOLD: assert property (ctrlWr && lowPwr && switchOn[0] && quiet_r > 4'h5
      && regWrData[2:0] == 3'b000 |-> ##2 switchOn[0])
    else $error("configuration changed in low power mode");
endmodule : hsc_switch_ctrl_props
`default_nettype wire

/* tb/hsc_load_bank.sv */
/* Load bank on the four switched outputs.
   Fault selects come from the bench; outputs feed the comparator inputs. */
`timescale 1ns/10ps
`default_nettype none
module hsc_load_bank (
  // Switch drive
  input wire logic [3:0] switchOn,
  // Load faults chosen by the bench
  input wire logic [3:0] shorted,
  input wire logic [3:0] opened,
  // Comparator outputs
  output logic [3:0] overCurrentPin,
  output logic [3:0] lowCurrentPin
);
  // An off switch carries no current, so its load reads as low current.
  assign overCurrentPin = switchOn & shorted;
  assign lowCurrentPin = ~switchOn | opened;
endmodule : hsc_load_bank
`default_nettype wire

/* tb/test_high_side_switch_control.sv */
/* Self-checking bench of the high-side switch controller.
   Drives the register port, mode, timers and supply pins; loads sit in hsc_load_bank. */
`timescale 1ns/10ps
`default_nettype none
module test_high_side_switch_control;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  wire logic [7:0] regRdData;
  hsc_pkg::hsc_mode_e chipMode = hsc_pkg::MODE_NORMAL;
  logic timerA = 1'b0;
  logic timerB = 1'b0;
  logic supplyOverPin = 1'b0;
  logic supplyUnderPin = 1'b0;
  logic [3:0] shorted = 4'h0;
  logic [3:0] opened = 4'h0;
  wire logic [3:0] overCurrentPin;
  wire logic [3:0] lowCurrentPin;
  wire logic [3:0] switchOn;
  int n_fail = 0;
  int cmp_count = 0;
  int cycN = 0;
  logic [31:0] seed = 32'd70;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cycN <= reset ? 0 : cycN + 1;

  hsc_switch_ctrl #(.OL_FILTER_CYCLES(8)) DUT (.sys_clk(sys_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .chipMode(chipMode), .timerA(timerA), .timerB(timerB),
    .supplyOverPin(supplyOverPin), .supplyUnderPin(supplyUnderPin),
    .overCurrentPin(overCurrentPin), .lowCurrentPin(lowCurrentPin), .switchOn(switchOn));
  hsc_load_bank loads (.switchOn(switchOn), .shorted(shorted), .opened(opened),
    .overCurrentPin(overCurrentPin), .lowCurrentPin(lowCurrentPin));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  function automatic logic src(input logic [2:0] c);
    return c == 3'b001 || (c == 3'b010 && timerA) || (c == 3'b011 && timerB);
  endfunction : src

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask : rc

  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  initial begin
    int fallA;
    int fallB;
    logic shut;
    logic keep;
    fallA = 0;
    fallB = 0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    for (int a = 0; a < 16; a = (a == 9) ? 15 : a + 1) begin
      rc(a[3:0], 8'h00);
    end
    wr(hsc_pkg::REG_PWM_DUTY_A, 8'd10);
    wr(hsc_pkg::REG_PWM_DUTY_B, 8'd3);
    wr(hsc_pkg::REG_PWM_FREQ, 8'h01);
    wr(hsc_pkg::REG_OUT_CTRL_B, 8'h54);
    cyc(2);
    chk({6'h0, switchOn[3:2]}, 8'h03);
    rc(hsc_pkg::REG_PWM_DUTY_A, 8'd10);
    rc(hsc_pkg::REG_PWM_DUTY_B, 8'd3);
    rc(hsc_pkg::REG_PWM_FREQ, 8'h01);
    while ((fallA == 0 || fallB == 0) && cycN < 12000) begin
      cyc(1);
      if (!switchOn[2] && fallA == 0) fallA = cycN;
      if (!switchOn[3] && fallB == 0) fallB = cycN;
    end
    chk({7'h0, fallA > 9750 && fallA < 9775}, 8'h01);
    chk({7'h0, fallB > 5849 && fallB < 5874}, 8'h01);
    wr(hsc_pkg::REG_OUT_CTRL_B, 8'h00);
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      @(posedge sys_clk);
      timerA <= seed[8];
      timerB <= seed[9];
      cyc(3);
      wr(hsc_pkg::REG_OUT_CTRL_A, {1'b0, seed[6:4], 1'b0, seed[2:0]});
      cyc(1);
      chk({6'h0, switchOn[1:0]}, {6'h0, src(seed[6:4]), src(seed[2:0])});
    end
    for (int m = 0; m < 2; m++) begin
      wr(hsc_pkg::REG_OUT_CTRL_A, 8'h11);
      @(posedge sys_clk);
      chipMode <= m ? hsc_pkg::MODE_FAILSAFE : hsc_pkg::MODE_RESTART;
      cyc(3);
      rc(hsc_pkg::REG_OUT_CTRL_A, 8'h00);
      chk({4'h0, switchOn}, 8'h00);
      wr(hsc_pkg::REG_OUT_CTRL_A, 8'h01);
      cyc(1);
      chk({4'h0, switchOn}, 8'h01);
      rc(hsc_pkg::REG_OUT_STATE, 8'h01);
      @(posedge sys_clk);
      chipMode <= hsc_pkg::MODE_NORMAL;
    end
    for (int m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      chipMode <= m ? hsc_pkg::MODE_SLEEP : hsc_pkg::MODE_STOP;
      wr(hsc_pkg::REG_OUT_CTRL_A, 8'h00);
      wr(hsc_pkg::REG_PWM_DUTY_A, 8'h55);
      rc(hsc_pkg::REG_OUT_CTRL_A, 8'h01);
      rc(hsc_pkg::REG_PWM_DUTY_A, 8'd10);
      chk({4'h0, switchOn}, 8'h01);
    end
    @(posedge sys_clk);
    chipMode <= hsc_pkg::MODE_NORMAL;
    for (int k = 0; k < 16; k++) begin
      shut = k[3] ? !k[1] : !k[0];
      keep = !shut || k[2];
      wr(hsc_pkg::REG_SUPPLY_CFG, {5'h0, k[2:0]});
      wr(hsc_pkg::REG_OUT_CTRL_A, 8'h01);
      @(posedge sys_clk);
      supplyUnderPin <= k[3];
      supplyOverPin <= !k[3];
      cyc(6);
      chk({7'h0, switchOn[0]}, {7'h0, !shut});
      rc(hsc_pkg::REG_SUPPLY_STAT, k[3] ? 8'h02 : 8'h01);
      rc(hsc_pkg::REG_OC_STAT, 8'h00);
      rc(hsc_pkg::REG_OL_STAT, 8'h00);
      @(posedge sys_clk);
      supplyOverPin <= 1'b0;
      supplyUnderPin <= 1'b0;
      for (int c = 0; c < 6; c++) begin
        cyc(1);
        if (!keep) chk({7'h0, switchOn[0]}, 8'h00);
      end
      chk({7'h0, switchOn[0]}, {7'h0, keep});
      rc(hsc_pkg::REG_OUT_CTRL_A, {7'h0, keep});
      wr(hsc_pkg::REG_SUPPLY_STAT, 8'h03);
    end
    wr(hsc_pkg::REG_OUT_CTRL_A, 8'h11);
    @(posedge sys_clk);
    shorted <= 4'h1;
    opened <= 4'h2;
    cyc(1590);
    chk({6'h0, switchOn[1:0]}, 8'h03);
    rc(hsc_pkg::REG_OL_STAT, 8'h02);
    cyc(20);
    chk({6'h0, switchOn[1:0]}, 8'h02);
    rc(hsc_pkg::REG_OC_STAT, 8'h01);
    rc(hsc_pkg::REG_OUT_CTRL_A, 8'h10);
    @(posedge sys_clk);
    shorted <= 4'h0;
    opened <= 4'h0;
    cyc(5);
    wr(hsc_pkg::REG_OC_STAT, 8'h01);
    wr(hsc_pkg::REG_OL_STAT, 8'h02);
    rc(hsc_pkg::REG_OC_STAT, 8'h00);
    rc(hsc_pkg::REG_OL_STAT, 8'h00);
    wr(hsc_pkg::REG_OUT_CTRL_A, 8'h11);
    cyc(1);
    chk({6'h0, switchOn[1:0]}, 8'h03);
    print_verdict();
  end
endmodule : test_high_side_switch_control

bind hsc_switch_ctrl hsc_switch_ctrl_props #(.OL_FILTER_CYCLES(OL_FILTER_CYCLES)) props (
  .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .chipMode(chipMode),
  .timerA(timerA), .timerB(timerB), .supplyOverPin(supplyOverPin),
  .supplyUnderPin(supplyUnderPin), .overCurrentPin(overCurrentPin),
  .lowCurrentPin(lowCurrentPin), .switchOn(switchOn));
`default_nettype wire
